/* File: common/dpdc_chan_if.sv */
`timescale 1ns/100ps
interface dpdc_chan_if
    import dpdc_pkg::*;
();
    logic [1:0] mode;
    logic [1:0] refSel;
    dpdc_en_s   en;

    // Controller side drives the settings and reads the enables.
    modport ctrl (output mode, output refSel, input en);
    // Sequencer side reads the settings and drives the enables.
    modport seq (input mode, input refSel, output en);
endinterface : dpdc_chan_if

/* File: common/dpdc_params.svh */
`ifndef DPDC_PARAMS_SVH
`define DPDC_PARAMS_SVH

// Channel count and register bus widths.
`define DPDC_NUM_CH      8
`define DPDC_AW          8
`define DPDC_DW          32
`define DPDC_FIELD_W     16

// Register offsets (byte addresses).
`define DPDC_OFF_VOL_PD  8'h00
`define DPDC_OFF_VOL_REF 8'h04
`define DPDC_OFF_NV_PD   8'h08
`define DPDC_OFF_NV_REF  8'h0C
`define DPDC_OFF_CMD     8'h10
`define DPDC_OFF_STATUS  8'h14

// Command and status bit positions.
`define DPDC_CMD_GC_RESET 0
`define DPDC_CMD_GC_WAKE  1
`define DPDC_STAT_BUSY    8

// Power-down mode and reference selection encodings.
`define DPDC_PD_NORMAL   2'h0
`define DPDC_PD_1K       2'h1
`define DPDC_PD_125K     2'h2
`define DPDC_PD_OPEN     2'h3
`define DPDC_REF_VDD     2'h0
`define DPDC_REF_BG      2'h1
`define DPDC_REF_PIN     2'h2
`define DPDC_REF_PIN_BUF 2'h3

// Reset values of the nonvolatile copies.
`define DPDC_NV_PD_RST   16'h0000
`define DPDC_NV_REF_RST  16'h0000

// Timing, in ns, and derived cycle counts (least times round up).
`define DPDC_CLK_NS      50
`define DPDC_ENTRY_NS    10000
`define DPDC_EXIT_NS     10000
`define DPDC_RSTDLY_NS   100000
`define DPDC_ENTRY_CYC ((`DPDC_ENTRY_NS + `DPDC_CLK_NS - 1) / `DPDC_CLK_NS)
`define DPDC_EXIT_CYC  ((`DPDC_EXIT_NS + `DPDC_CLK_NS - 1) / `DPDC_CLK_NS)
`define DPDC_RSTDLY_CYC ((`DPDC_RSTDLY_NS + `DPDC_CLK_NS - 1) / `DPDC_CLK_NS)
`define DPDC_CNT_W       12

`endif

/* File: common/dpdc_pkg.sv */
package dpdc_pkg;

    // Channel sequencer states, Gray coded along the usual cycle.
    typedef enum logic [1:0] {
        ST_NORMAL = 2'h0,
        ST_ENTER  = 2'h1,
        ST_DOWN   = 2'h3,
        ST_EXIT   = 2'h2
    } dpdc_state_e;

    // Analog circuit enables of one channel.
    typedef struct packed {
        logic ampPower;
        logic ampDrive;
        logic pd1k;
        logic pd125k;
        logic ladderConn;
        logic ladderVdd;
        logic ladderPin;
        logic ladderBuf;
        logic bandGap;
    } dpdc_en_s;

    // Enables for normal mode with the supply as reference.
    localparam dpdc_en_s DPDC_EN_RST = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1,
                                         1'b1, 1'b0, 1'b0, 1'b0};

endpackage : dpdc_pkg

/* File: rtl/dpdc_chan_seq.sv */
`timescale 1ns/100ps
`include "dpdc_params.svh"
module dpdc_chan_seq
    import dpdc_pkg::*;
#(
    parameter int ENTRY_CYC = `DPDC_ENTRY_CYC,
    parameter int EXIT_CYC  = `DPDC_EXIT_CYC
) (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic clkEn,
    dpdc_chan_if.seq  chan
);
    localparam int CW = `DPDC_CNT_W;
    localparam logic [CW-1:0] ENTRY_LOAD = CW'(ENTRY_CYC - 1);
    localparam logic [CW-1:0] EXIT_LOAD  = CW'(EXIT_CYC - 1);

    dpdc_state_e   state_ff;
    dpdc_state_e   nxt_state;
    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;
    logic [1:0]    lastMode_ff;
    logic [1:0]    nxt_lastMode;
    dpdc_en_s      en_ff;
    dpdc_en_s      nxt_en;
    logic          modeChg;
    logic          powered;
    logic          isNormal;

    assign isNormal = (chan.mode == `DPDC_PD_NORMAL);
    assign modeChg  = (chan.mode != lastMode_ff);

    // Delays run on counters; a new power-down mode during the entry wait restarts it.
    always_comb begin
        nxt_state    = state_ff;
        nxt_cnt      = cnt_ff;
        nxt_lastMode = chan.mode;
        case (state_ff)
            ST_NORMAL: begin
                if (!isNormal) begin
                    nxt_state = ST_ENTER;
                    nxt_cnt   = ENTRY_LOAD;
                end
            end
            ST_ENTER: begin
                if (isNormal) begin
                    nxt_state = ST_NORMAL;
                end else if (modeChg) begin
                    nxt_cnt = ENTRY_LOAD;
                end else if (cnt_ff == '0) begin
                    nxt_state = ST_DOWN;
                end else begin
                    nxt_cnt = cnt_ff - 1'b1;
                end
            end
            ST_DOWN: begin
                if (isNormal) begin
                    nxt_state = ST_EXIT;
                    nxt_cnt   = EXIT_LOAD;
                end
            end
            ST_EXIT: begin
                if (!isNormal) begin
                    nxt_state = ST_DOWN;
                end else if (cnt_ff == '0) begin
                    nxt_state = ST_NORMAL;
                end else begin
                    nxt_cnt = cnt_ff - 1'b1;
                end
            end
            default: begin
                nxt_state = ST_NORMAL;
            end
        endcase
        // Amp and ladder are up in every state but DOWN, so the exit wait
        // already has the ladder connected and the amp powered, with only its drive held off.
        powered           = (nxt_state != ST_DOWN);
        nxt_en.ampPower   = powered;
        nxt_en.ampDrive   = (nxt_state == ST_NORMAL) ||
                            (nxt_state == ST_ENTER);
        nxt_en.pd1k       = (nxt_state == ST_DOWN) &&
                            (chan.mode == `DPDC_PD_1K);
        nxt_en.pd125k     = (nxt_state == ST_DOWN) &&
                            (chan.mode == `DPDC_PD_125K);
        nxt_en.ladderConn = powered;
        nxt_en.ladderVdd  = powered && (chan.refSel != `DPDC_REF_PIN);
        nxt_en.ladderPin  = powered && (chan.refSel == `DPDC_REF_PIN);
        nxt_en.ladderBuf  = powered && chan.refSel[0];
        nxt_en.bandGap    = (chan.refSel == `DPDC_REF_BG);
    end

    // State and enables are held while the clock enable is low.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_ff    <= ST_NORMAL;
            cnt_ff      <= '0;
            lastMode_ff <= `DPDC_PD_NORMAL;
            en_ff       <= DPDC_EN_RST;
        end else if (clkEn) begin
            state_ff    <= nxt_state;
            cnt_ff      <= nxt_cnt;
            lastMode_ff <= nxt_lastMode;
            en_ff       <= nxt_en;
        end
    end

    assign chan.en = en_ff;

    a_entry_delay: assert property (@(posedge clk) disable iff (!nrst)
        (state_ff == ST_NORMAL && !isNormal && clkEn) |=> en_ff.ampDrive[*8])
        else $error("Amplifier stopped before entry delay.");
    a_down_off: assert property (@(posedge clk) disable iff (!nrst)
        (state_ff == ST_DOWN) |-> !en_ff.ampDrive && !en_ff.ladderConn)
        else $error("Circuits enabled while powered down.");
    a_exit_delay: assert property (@(posedge clk) disable iff (!nrst)
        (state_ff == ST_DOWN && isNormal && clkEn) |=>
        (!en_ff.ampDrive && en_ff.ladderConn)[*8])
        else $error("Amplifier drove before exit delay.");
    a_pull_mode: assert property (@(posedge clk) disable iff (!nrst)
        en_ff.pd1k |-> !en_ff.pd125k && !en_ff.ampPower)
        else $error("Pull-down engaged in wrong state.");
endmodule : dpdc_chan_seq

/* File: rtl/dpdc_pin_sync.sv */
`timescale 1ns/100ps
module dpdc_pin_sync (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic clkEn,
    input  wire logic pinIn,
    output logic      level
);
    logic meta_ff;
    logic s2_ff;
    logic s3_ff;
    logic level_ff;
    logic nxt_level;

    // A change counts only once stages two and three agree.
    always_comb begin
        nxt_level = (s2_ff == s3_ff) ? s3_ff : level_ff;
    end

    // The first stage feeds the second stage and nothing else.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_ff  <= 1'b0;
            s2_ff    <= 1'b0;
            s3_ff    <= 1'b0;
            level_ff <= 1'b0;
        end else if (clkEn) begin
            meta_ff  <= pinIn;
            s2_ff    <= meta_ff;
            s3_ff    <= s2_ff;
            level_ff <= nxt_level;
        end
    end

    assign level = level_ff;
endmodule : dpdc_pin_sync

/* File: rtl/dpdc_power_down_ctrl.sv */
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`include "dpdc_params.svh"
module dpdc_power_down_ctrl
    import dpdc_pkg::*;
(
    input  wire logic                     clk,
    input  wire logic                     clkEn,
    input  wire logic                     nrst,
    input  wire logic                     porPin,
    input  wire logic [`DPDC_AW-1:0]      regAddr,
    input  wire logic [`DPDC_DW-1:0]      regWdata,
    input  wire logic                     regWr,
    input  wire logic                     regRd,
    output logic      [`DPDC_DW-1:0]      regRdata,
    output logic      [`DPDC_NUM_CH-1:0]  ampPower,
    output logic      [`DPDC_NUM_CH-1:0]  ampDrive,
    output logic      [`DPDC_NUM_CH-1:0]  pullDown1k,
    output logic      [`DPDC_NUM_CH-1:0]  pullDown125k,
    output logic      [`DPDC_NUM_CH-1:0]  ladderConn,
    output logic      [`DPDC_NUM_CH-1:0]  ladderFromVdd,
    output logic      [`DPDC_NUM_CH-1:0]  ladderFromPin,
    output logic      [`DPDC_NUM_CH-1:0]  ladderBufEn,
    output logic      [`DPDC_NUM_CH-1:0]  bandGapEn,
    output logic                          resetDelayBusy
);
    localparam int NCH = `DPDC_NUM_CH;
    localparam int FW  = `DPDC_FIELD_W;
    localparam int CW  = `DPDC_CNT_W;
    localparam logic [CW-1:0] RSTDLY_LOAD = CW'(`DPDC_RSTDLY_CYC - 1);

    logic [FW-1:0]          volPd_ff;
    logic [FW-1:0]          nxt_volPd;
    logic [FW-1:0]          volRef_ff;
    logic [FW-1:0]          nxt_volRef;
    logic [FW-1:0]          nvPd_ff;
    logic [FW-1:0]          nxt_nvPd;
    logic [FW-1:0]          nvRef_ff;
    logic [FW-1:0]          nxt_nvRef;
    logic [CW-1:0]          busyCnt_ff;
    logic [CW-1:0]          nxt_busyCnt;
    logic                   busy_ff;
    logic                   nxt_busy;
    logic                   porQ_ff;
    logic [`DPDC_DW-1:0]    rdata_ff;
    logic [`DPDC_DW-1:0]    nxt_rdata;
    logic                   porLvl;
    logic                   porEvt;
    logic                   cmdWr;
    logic                   gcReset;
    logic                   gcWake;
    logic [NCH-1:0]         driving;

    // The reset detector pin is asynchronous, so it is filtered first.
    dpdc_pin_sync u_porSync (
        .clk   (clk),
        .nrst  (nrst),
        .clkEn (clkEn),
        .pinIn (porPin),
        .level (porLvl)
    );

    // A rising reset level is one reload event.
    assign porEvt  = porLvl && !porQ_ff;
    assign cmdWr   = regWr && (regAddr == `DPDC_OFF_CMD);
    assign gcReset = cmdWr && regWdata[`DPDC_CMD_GC_RESET];
    assign gcWake  = cmdWr && regWdata[`DPDC_CMD_GC_WAKE];

    // Register updates. Later statements take priority, so a power-on
    // reload beats a general call, which beats a plain field write.
    always_comb begin
        nxt_volPd   = volPd_ff;
        nxt_volRef  = volRef_ff;
        nxt_nvPd    = nvPd_ff;
        nxt_nvRef   = nvRef_ff;
        nxt_busyCnt = busyCnt_ff;
        nxt_rdata   = '0;
        if (busyCnt_ff != '0) begin
            nxt_busyCnt = busyCnt_ff - 1'b1;
        end
        // Writes are accepted whatever the channels' modes are.
        if (regWr) begin
            case (regAddr)
                `DPDC_OFF_VOL_PD: begin
                    nxt_volPd = regWdata[FW-1:0];
                end
                `DPDC_OFF_VOL_REF: begin
                    nxt_volRef = regWdata[FW-1:0];
                end
                `DPDC_OFF_NV_PD: begin
                    nxt_nvPd = regWdata[FW-1:0];
                end
                `DPDC_OFF_NV_REF: begin
                    nxt_nvRef = regWdata[FW-1:0];
                end
                default: begin
                end
            endcase
        end
        // General-call reset reloads the settings, but no reset timer.
        if (gcReset) begin
            nxt_volPd  = nvPd_ff;
            nxt_volRef = nvRef_ff;
        end
        // Wake-up forces every channel back to normal mode.
        if (gcWake) begin
            nxt_volPd = '0;
        end
        // Power-on reload, with the reset delay timer started.
        if (porEvt) begin
            nxt_volPd   = nvPd_ff;
            nxt_volRef  = nvRef_ff;
            nxt_busyCnt = RSTDLY_LOAD;
        end
        nxt_busy = (nxt_busyCnt != '0);
        // Read data stand only in the cycle after the strobe.
        if (regRd) begin
            case (regAddr)
                `DPDC_OFF_VOL_PD: begin
                    nxt_rdata[FW-1:0] = volPd_ff;
                end
                `DPDC_OFF_VOL_REF: begin
                    nxt_rdata[FW-1:0] = volRef_ff;
                end
                `DPDC_OFF_NV_PD: begin
                    nxt_rdata[FW-1:0] = nvPd_ff;
                end
                `DPDC_OFF_NV_REF: begin
                    nxt_rdata[FW-1:0] = nvRef_ff;
                end
                `DPDC_OFF_STATUS: begin
                    nxt_rdata[NCH-1:0]         = driving;
                    nxt_rdata[`DPDC_STAT_BUSY] = busy_ff;
                end
                default: begin
                end
            endcase
        end
    end

    // Powering down never touches these; only the paths above do.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            volPd_ff   <= `DPDC_NV_PD_RST;
            volRef_ff  <= `DPDC_NV_REF_RST;
            nvPd_ff    <= `DPDC_NV_PD_RST;
            nvRef_ff   <= `DPDC_NV_REF_RST;
            busyCnt_ff <= '0;
            busy_ff    <= 1'b0;
            porQ_ff    <= 1'b0;
            rdata_ff   <= '0;
        end else if (clkEn) begin
            volPd_ff   <= nxt_volPd;
            volRef_ff  <= nxt_volRef;
            nvPd_ff    <= nxt_nvPd;
            nvRef_ff   <= nxt_nvRef;
            busyCnt_ff <= nxt_busyCnt;
            busy_ff    <= nxt_busy;
            porQ_ff    <= porLvl;
            rdata_ff   <= nxt_rdata;
        end
    end

    assign regRdata       = rdata_ff;
    assign resetDelayBusy = busy_ff;

    // One independent sequencer per channel, fed from its own fields.
    for (genvar i = 0; i < NCH; i++) begin : g_ch
        dpdc_chan_if chIf ();
        assign chIf.mode   = volPd_ff[2*i +: 2];
        assign chIf.refSel = volRef_ff[2*i +: 2];
        dpdc_chan_seq u_seq (
            .clk   (clk),
            .nrst  (nrst),
            .clkEn (clkEn),
            .chan  (chIf.seq)
        );
        assign ampPower[i]      = chIf.en.ampPower;
        assign ampDrive[i]      = chIf.en.ampDrive;
        assign pullDown1k[i]    = chIf.en.pd1k;
        assign pullDown125k[i]  = chIf.en.pd125k;
        assign ladderConn[i]    = chIf.en.ladderConn;
        assign ladderFromVdd[i] = chIf.en.ladderVdd;
        assign ladderFromPin[i] = chIf.en.ladderPin;
        assign ladderBufEn[i]   = chIf.en.ladderBuf;
        assign bandGapEn[i]     = chIf.en.bandGap;
        assign driving[i]       = chIf.en.ampDrive;
    end

    a_wake_clear: assert property (@(posedge clk) disable iff (!nrst)
        (gcWake && !porEvt && clkEn) |=> (volPd_ff == '0))
        else $error("Wake-up did not clear the modes.");
    a_por_reload: assert property (@(posedge clk) disable iff (!nrst)
        (porEvt && clkEn) |=> (volPd_ff == $past(nvPd_ff)) &&
        (volRef_ff == $past(nvRef_ff)) && busy_ff)
        else $error("Power-on reload failed.");
    a_gc_no_timer: assert property (@(posedge clk) disable iff (!nrst)
        (gcReset && !porEvt && !busy_ff && clkEn) |=>
        !busy_ff && (volPd_ff == $past(nvPd_ff)))
        else $error("General-call reset misbehaved.");
    a_pd_source: assert property (@(posedge clk) disable iff (!nrst)
        (volPd_ff != $past(volPd_ff)) |-> $past(regWr || porEvt))
        else $error("Mode field changed without a cause.");
    a_busy_hold: assert property (@(posedge clk) disable iff (!nrst)
        $rose(busy_ff) |-> busy_ff[*8])
        else $error("Reset delay ended too early.");
endmodule : dpdc_power_down_ctrl

/* File: testbench/dac_channel_power_down_control_tb.sv */
`timescale 1ns/100ps
`include "dpdc_params.svh"
module dac_channel_power_down_control_tb;
    logic        clk;
    logic        nrst;
    logic        clkEn;
    logic        porPin;
    logic [7:0]  regAddr;
    logic [31:0] regWdata;
    logic        regWr;
    logic        regRd;
    logic [31:0] regRdata;
    logic [7:0]  ampPower;
    logic [7:0]  ampDrive;
    logic [7:0]  pullDown1k;
    logic [7:0]  pullDown125k;
    logic [7:0]  ladderConn;
    logic [7:0]  ladderFromVdd;
    logic [7:0]  ladderFromPin;
    logic [7:0]  ladderBufEn;
    logic [7:0]  bandGapEn;
    logic        resetDelayBusy;
    logic [31:0] rdv;
    int          nErrors;
    int          checked;

    dpdc_power_down_ctrl i_dut (
        .clk(clk), .clkEn(clkEn), .nrst(nrst), .porPin(porPin),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .ampPower(ampPower),
        .ampDrive(ampDrive), .pullDown1k(pullDown1k),
        .pullDown125k(pullDown125k), .ladderConn(ladderConn),
        .ladderFromVdd(ladderFromVdd), .ladderFromPin(ladderFromPin),
        .ladderBufEn(ladderBufEn), .bandGapEn(bandGapEn),
        .resetDelayBusy(resetDelayBusy)
    );

    dpdc_host_model i_host (
        .regRdata(regRdata), .clk(clk), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd)
    );

    // Clock of 50 ns period.
    initial clk = 1'b0;
    always #25 clk = ~clk;

    // Compares one value and counts it; four-state compare catches unknowns.
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        checked++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, g);
            nErrors++;
        end
    endtask : chk

    task automatic cyc(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic close_out();
        if (nErrors == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out

    // Reset leaves every channel driving from the supply.
    task automatic t_reset();
        chk("ampDrive", 32'h0000_00FF, 32'(ampDrive));
        chk("pullDown1k", 32'h0000_0000, 32'(pullDown1k));
        chk("ladderFromVdd", 32'h0000_00FF, 32'(ladderFromVdd));
        i_host.rd(8'h20, rdv);
        chk("unmapped", 32'h0000_0000, rdv);
    endtask : t_reset

    // Three channels enter different modes, the rest keep running.
    task automatic t_modes();
        i_host.wr(`DPDC_OFF_VOL_PD, 32'h0000_0039);
        cyc(150);
        chk("ampDrive wait", 32'h0000_00FF, 32'(ampDrive));
        cyc(70);
        chk("ampDrive", 32'h0000_00F8, 32'(ampDrive));
        chk("ampPower", 32'h0000_00F8, 32'(ampPower));
        chk("ladderConn", 32'h0000_00F8, 32'(ladderConn));
        chk("pullDown1k", 32'h0000_0001, 32'(pullDown1k));
        chk("pullDown125k", 32'h0000_0002, 32'(pullDown125k));
        i_host.rd(`DPDC_OFF_STATUS, rdv);
        chk("status", 32'h0000_00F8, rdv);
        i_host.rd(`DPDC_OFF_VOL_PD, rdv);
        chk("volPd", 32'h0000_0039, rdv);
        i_host.wr(`DPDC_OFF_VOL_PD, 32'h0000_0000);
        cyc(3);
        chk("exit pullDown1k", 32'h0000_0000, 32'(pullDown1k));
        chk("exit ampPower", 32'h0000_00FF, 32'(ampPower));
        chk("exit ladderConn", 32'h0000_00FF, 32'(ladderConn));
        chk("exit ampDrive", 32'h0000_00F8, 32'(ampDrive));
        cyc(217);
        chk("ampDrive back", 32'h0000_00FF, 32'(ampDrive));
    endtask : t_modes

    // A mode change during the entry wait starts the count again.
    task automatic t_restart();
        i_host.wr(`DPDC_OFF_VOL_PD, 32'h0000_0001);
        cyc(100);
        i_host.wr(`DPDC_OFF_VOL_PD, 32'h0000_0002);
        cyc(150);
        chk("restart ampDrive", 32'h0000_00FF, 32'(ampDrive));
        cyc(70);
        chk("restart pd125k", 32'h0000_0001, 32'(pullDown125k));
    endtask : t_restart

    // Every reference code, then band gap kept alive in power-down.
    task automatic t_refs();
        logic [7:0] r;
        // Channel 0 is still powered down here; bring it back so that its
        // ladder enables follow the reference code like the others.
        i_host.wr(`DPDC_OFF_VOL_PD, 32'h0000_0000);
        for (int i = 0; i < 4; i++) begin
            r = {4{i[1:0]}};
            i_host.wr(`DPDC_OFF_VOL_REF, {16'h0000, r, r});
            cyc(3);
            chk("ladderBufEn", (i[0] ? 32'hFF : 32'h0),
                32'(ladderBufEn));
            chk("bandGapEn", (i == 1 ? 32'hFF : 32'h0),
                32'(bandGapEn));
            chk("ladderFromPin", (i == 2 ? 32'hFF : 32'h0),
                32'(ladderFromPin));
        end
        i_host.wr(`DPDC_OFF_VOL_REF, 32'h0000_5555);
        i_host.wr(`DPDC_OFF_VOL_PD, 32'h0000_5555);
        cyc(220);
        chk("pd bandGapEn", 32'h0000_00FF, 32'(bandGapEn));
        chk("pd ladderBufEn", 32'h0000_0000, 32'(ladderBufEn));
        chk("pd ladderFromVdd", 32'h0000_0000, 32'(ladderFromVdd));
    endtask : t_refs

    // General-call wake-up followed by general-call reset.
    task automatic t_general_call();
        i_host.wr(`DPDC_OFF_NV_PD, 32'h0000_0002);
        i_host.rd(`DPDC_OFF_VOL_PD, rdv);
        chk("volPd kept", 32'h0000_5555, rdv);
        i_host.wake_then_reset(rdv);
        chk("volPd woken", 32'h0000_0000, rdv);
        i_host.rd(`DPDC_OFF_VOL_PD, rdv);
        chk("volPd reset", 32'h0000_0002, rdv);
        i_host.rd(`DPDC_OFF_VOL_REF, rdv);
        chk("volRef reset", 32'h0000_0000, rdv);
        chk("busy", 32'h0000_0000, 32'(resetDelayBusy));
        cyc(220);
        chk("gc ampDrive", 32'h0000_00FE, 32'(ampDrive));
        chk("gc pd125k", 32'h0000_0001, 32'(pullDown125k));
    endtask : t_general_call

    // Power-on event reloads the volatile copies and runs the delay.
    task automatic t_por();
        i_host.wr(`DPDC_OFF_NV_REF, 32'h0000_000B);
        i_host.wr(`DPDC_OFF_NV_PD, 32'h0000_0000);
        porPin <= 1'b1;
        cyc(8);
        chk("busy por", 32'h0000_0001, 32'(resetDelayBusy));
        i_host.rd(`DPDC_OFF_VOL_REF, rdv);
        chk("volRef por", 32'h0000_000B, rdv);
        i_host.rd(`DPDC_OFF_VOL_PD, rdv);
        chk("volPd por", 32'h0000_0000, rdv);
        porPin <= 1'b0;
        cyc(2100);
        chk("busy end", 32'h0000_0000, 32'(resetDelayBusy));
        chk("por ampDrive", 32'h0000_00FF, 32'(ampDrive));
    endtask : t_por

    // Limit well beyond the roughly 3400 cycles the sequence needs.
    initial begin
        repeat (40000) @(posedge clk);
        nErrors++;
        close_out();
    end

    // Main sequence: reset for 8 cycles, then each scenario in turn.
    initial begin
        nErrors = 0;
        checked = 0;
        nrst    = 1'b0;
        clkEn   = 1'b1;
        porPin  = 1'b0;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        cyc(1);
        t_reset();
        t_modes();
        t_restart();
        t_refs();
        t_general_call();
        t_por();
        close_out();
    end

endmodule : dac_channel_power_down_control_tb

/* File: testbench/dpdc_host_model.sv */
`timescale 1ns/100ps
`include "dpdc_params.svh"
module dpdc_host_model (
    input  wire logic [`DPDC_DW-1:0] regRdata,
    input  wire logic                clk,
    output logic      [`DPDC_AW-1:0] regAddr,
    output logic      [`DPDC_DW-1:0] regWdata,
    output logic                     regWr,
    output logic                     regRd
);

    // The bus idles quiet until the first request is made.
    initial begin
        regAddr  = 8'h00;
        regWdata = 32'h0000_0000;
        regWr    = 1'b0;
        regRd    = 1'b0;
    end

    // One write cycle; released lines are inverted so no stale value helps.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge clk);
        regWr    <= 1'b0;
        regAddr  <= ~a;
        regWdata <= ~d;
    endtask : wr

    // One read cycle; the answer is only valid in the following cycle.
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge clk);
        regRd   <= 1'b0;
        regAddr <= ~a;
        #1;
        d = regRdata;
    endtask : rd

    // Wake-up is always chased by a reset to avoid the excess current.
    task automatic wake_then_reset(output logic [31:0] pdBetween);
        wr(`DPDC_OFF_CMD, 32'h0000_0002);
        rd(`DPDC_OFF_VOL_PD, pdBetween);
        wr(`DPDC_OFF_CMD, 32'h0000_0001);
    endtask : wake_then_reset

endmodule : dpdc_host_model
